// ===== codec_clock_sync.sv
`timescale 1ns/10ps
package codec_clock_pkg;

  typedef enum logic [2:0] {
    MODE_EXT_SLAVE      = 3'b000,
    MODE_EXT_MASTER     = 3'b001,
    MODE_PLL_SLAVE_MCLK = 3'b010,
    MODE_PLL_SLAVE_FB   = 3'b011,
    MODE_PLL_MASTER     = 3'b100
  } clock_mode_t;

  typedef enum logic [1:0] {
    REF_KIND_NONE  = 2'b00,
    REF_KIND_FRAME = 2'b01,
    REF_KIND_BIT   = 2'b10,
    REF_KIND_MCLK  = 2'b11
  } ref_kind_t;

  // reference select codes
  localparam logic [3:0] REF_FRAME_1FS    = 4'h0;
  localparam logic [3:0] REF_BIT_32FS     = 4'h2;
  localparam logic [3:0] REF_BIT_64FS     = 4'h3;
  localparam logic [3:0] REF_MCLK_11M2896 = 4'h4;
  localparam logic [3:0] REF_MCLK_12M     = 4'h6;
  localparam logic [3:0] REF_MCLK_24M     = 4'h7;
  localparam logic [3:0] REF_MCLK_13M5    = 4'hc;
  localparam logic [3:0] REF_MCLK_27M     = 4'hd;

  // sample rate codes with master clock reference
  localparam logic [3:0] FS_CODE_8K     = 4'h0;
  localparam logic [3:0] FS_CODE_12K    = 4'h1;
  localparam logic [3:0] FS_CODE_16K    = 4'h2;
  localparam logic [3:0] FS_CODE_24K    = 4'h3;
  localparam logic [3:0] FS_CODE_7K35   = 4'h4;
  localparam logic [3:0] FS_CODE_11K025 = 4'h5;
  localparam logic [3:0] FS_CODE_14K7   = 4'h6;
  localparam logic [3:0] FS_CODE_22K05  = 4'h7;
  localparam logic [3:0] FS_CODE_32K    = 4'ha;
  localparam logic [3:0] FS_CODE_48K    = 4'hb;
  localparam logic [3:0] FS_CODE_29K4   = 4'he;
  localparam logic [3:0] FS_CODE_44K1   = 4'hf;

  localparam logic [15:0] FS_NONE_HZ   = 16'h0000;
  localparam logic [15:0] FS_8K_HZ     = 16'h1f40;
  localparam logic [15:0] FS_12K_HZ    = 16'h2ee0;
  localparam logic [15:0] FS_16K_HZ    = 16'h3e80;
  localparam logic [15:0] FS_24K_HZ    = 16'h5dc0;
  localparam logic [15:0] FS_7K35_HZ   = 16'h1cb6;
  localparam logic [15:0] FS_11K025_HZ = 16'h2b11;
  localparam logic [15:0] FS_14K7_HZ   = 16'h396c;
  localparam logic [15:0] FS_22K05_HZ  = 16'h5622;
  localparam logic [15:0] FS_32K_HZ    = 16'h7d00;
  localparam logic [15:0] FS_48K_HZ    = 16'hbb80;
  localparam logic [15:0] FS_29K4_HZ   = 16'h72d8;
  localparam logic [15:0] FS_44K1_HZ   = 16'hac44;

  // fs range with frame or bit clock reference
  localparam logic [1:0] RANGE_LOW  = 2'h0;
  localparam logic [1:0] RANGE_MID  = 2'h1;
  localparam logic [1:0] RANGE_HIGH = 2'h2;
  localparam logic [1:0] RANGE_NONE = 2'h3;

  // master clock ratio in external slave mode
  localparam logic [1:0] RATIO_SEL_256A = 2'h0;
  localparam logic [1:0] RATIO_SEL_1024 = 2'h1;
  localparam logic [1:0] RATIO_SEL_512  = 2'h2;
  localparam logic [1:0] MULT_256       = 2'h0;
  localparam logic [1:0] MULT_512       = 2'h1;
  localparam logic [1:0] MULT_1024      = 2'h2;

  // one frame is 512 link clock cycles; phase bit n has period 2^(n+1)
  localparam int         PHASE_W      = 9;
  localparam int         FRAME_IDX    = 8;
  localparam int         BIT_32FS_IDX = 3;
  localparam int         BIT_64FS_IDX = 2;
  localparam logic [8:0] PHASE_ZERO   = 9'h000;
  localparam logic [8:0] PHASE_STEP   = 9'h001;

  // lock times
  localparam int SYS_CLK_KHZ    = 25000;
  localparam int LOCK_FRAME_MS  = 160;
  localparam int LOCK_BIT_MS    = 2;
  localparam int LOCK_MCLK_MS   = 10;
  localparam int LOCK_FRAME_CYC = LOCK_FRAME_MS * SYS_CLK_KHZ;
  localparam int LOCK_BIT_CYC   = LOCK_BIT_MS * SYS_CLK_KHZ;
  localparam int LOCK_MCLK_CYC  = LOCK_MCLK_MS * SYS_CLK_KHZ;
  localparam int LOCK_W         = 23;

  localparam int LINK_SYNC_W = 7;

  function automatic logic [15:0] fs_code_to_hz(input logic [3:0] code);
    case (code)
      FS_CODE_8K:     fs_code_to_hz = FS_8K_HZ;
      FS_CODE_12K:    fs_code_to_hz = FS_12K_HZ;
      FS_CODE_16K:    fs_code_to_hz = FS_16K_HZ;
      FS_CODE_24K:    fs_code_to_hz = FS_24K_HZ;
      FS_CODE_7K35:   fs_code_to_hz = FS_7K35_HZ;
      FS_CODE_11K025: fs_code_to_hz = FS_11K025_HZ;
      FS_CODE_14K7:   fs_code_to_hz = FS_14K7_HZ;
      FS_CODE_22K05:  fs_code_to_hz = FS_22K05_HZ;
      FS_CODE_32K:    fs_code_to_hz = FS_32K_HZ;
      FS_CODE_48K:    fs_code_to_hz = FS_48K_HZ;
      FS_CODE_29K4:   fs_code_to_hz = FS_29K4_HZ;
      FS_CODE_44K1:   fs_code_to_hz = FS_44K1_HZ;
      default:        fs_code_to_hz = FS_NONE_HZ;
    endcase
  endfunction

  function automatic ref_kind_t ref_kind(input logic [3:0] code);
    case (code)
      REF_FRAME_1FS:                 ref_kind = REF_KIND_FRAME;
      REF_BIT_32FS, REF_BIT_64FS:    ref_kind = REF_KIND_BIT;
      REF_MCLK_11M2896, REF_MCLK_12M,
      REF_MCLK_24M, REF_MCLK_13M5,
      REF_MCLK_27M:                  ref_kind = REF_KIND_MCLK;
      default:                       ref_kind = REF_KIND_NONE;
    endcase
  endfunction

endpackage

module codec_clock_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_en,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  always_comb begin
    next_s = s;
    if (i_en) begin
      next_s.s1 = i_d;
      next_s.s2 = s.s1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_q = s.s2;
endmodule

// ===== codec_clock_mode_control.sv
`timescale 1ns/10ps
module codec_clock_mode_control
  import codec_clock_pkg::*;
#(
  parameter int LOCK_FRAME_CYCLES = LOCK_FRAME_CYC,
  parameter int LOCK_BIT_CYCLES   = LOCK_BIT_CYC,
  parameter int LOCK_MCLK_CYCLES  = LOCK_MCLK_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_clk_en,
  input  wire logic        i_sys_rst,
  input  wire logic        i_master_clock_in,
  input  wire logic        i_master_select,
  input  wire logic        i_pll_power,
  input  wire logic [3:0]  i_pll_ref_select,
  input  wire logic [3:0]  i_sample_rate_select,
  input  wire logic [1:0]  i_mclk_ratio_select,
  input  wire logic [1:0]  i_mclk_out_divider,
  input  wire logic        i_mclk_out_enable,
  input  wire logic        i_bit_clock_rate,
  input  wire logic        i_bit_clock,
  input  wire logic        i_frame_clock,
  output logic             o_master_clock_out,
  output logic             o_bit_clock,
  output logic             o_bit_clock_oe,
  output logic             o_frame_clock,
  output logic             o_frame_clock_oe,
  output clock_mode_t      o_clock_mode,
  output logic             o_pll_running,
  output logic             o_pll_locked,
  output logic             o_config_supported,
  output logic [15:0]      o_sample_rate_hz,
  output logic [1:0]       o_fs_range,
  output logic [1:0]       o_mclk_ratio,
  output logic             o_data_invalid
);

  ////////////////////////////////////////////////////////////////////////////
  // system clock domain: mode decode, config check, lock timing

  typedef struct packed {
    logic              clk_en_d;
    logic              master;
    logic              pll_power_d;
    logic [3:0]        ref_d;
    logic [3:0]        fs_d;
    logic              mclk_en;
    logic [1:0]        divider;
    logic              bit_rate;
    logic              bit_d;
    logic              frame_d;
    logic              ref_seen;
    logic [LOCK_W-1:0] lock_cnt;
    logic              locked;
    clock_mode_t       mode;
    logic              supported;
    logic [15:0]       fs_hz;
    logic [1:0]        fs_range;
    logic [1:0]        mclk_mult;
    logic              data_invalid;
  } sys_state_t;

  sys_state_t        s;
  sys_state_t        next_s;
  logic [1:0]        pin_sync;
  ref_kind_t         kind;
  logic              restart;
  logic              ref_edge;
  logic              rate_ok;
  logic [LOCK_W-1:0] lock_lim;

  // bit and frame clock pins are asynchronous to i_clk
  codec_clock_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .i_clk (i_clk),
    .i_rst (i_sys_rst),
    .i_en  (i_clk_en),
    .i_d   ({i_bit_clock, i_frame_clock}),
    .o_q   (pin_sync)
  );

  always_comb begin
    next_s   = s;
    kind     = ref_kind(i_pll_ref_select);
    restart  = 1'b0;
    ref_edge = 1'b0;
    rate_ok  = 1'b0;
    lock_lim = '0;
    // clock enable crosses to the link side unfrozen, else the link never freezes
    next_s.clk_en_d = i_clk_en;
    if (i_clk_en) begin
      next_s.master      = i_master_select;
      next_s.pll_power_d = i_pll_power;
      next_s.ref_d       = i_pll_ref_select;
      next_s.fs_d        = i_sample_rate_select;
      next_s.mclk_en     = i_mclk_out_enable;
      next_s.divider     = i_mclk_out_divider;
      next_s.bit_rate    = i_bit_clock_rate;
      next_s.bit_d       = pin_sync[1];
      next_s.frame_d     = pin_sync[0];

      if (!i_pll_power) begin
        next_s.mode = i_master_select ? MODE_EXT_MASTER : MODE_EXT_SLAVE;
      end else if (i_master_select) begin
        next_s.mode = MODE_PLL_MASTER;
      end else if (i_pll_ref_select[2]) begin
        next_s.mode = MODE_PLL_SLAVE_MCLK;
      end else begin
        next_s.mode = MODE_PLL_SLAVE_FB;
      end

      next_s.fs_hz    = fs_code_to_hz(i_sample_rate_select);
      next_s.fs_range = i_sample_rate_select[3:2];
      unique case (kind)
        REF_KIND_FRAME: begin
          rate_ok  = (i_sample_rate_select[3:2] != RANGE_NONE);
          lock_lim = LOCK_W'(LOCK_FRAME_CYCLES - 1);
          ref_edge = pin_sync[0] ^ s.frame_d;
        end
        REF_KIND_BIT: begin
          rate_ok  = (i_sample_rate_select[3:2] != RANGE_NONE);
          lock_lim = LOCK_W'(LOCK_BIT_CYCLES - 1);
          ref_edge = pin_sync[1] ^ s.bit_d;
        end
        REF_KIND_MCLK: begin
          rate_ok  = (fs_code_to_hz(i_sample_rate_select) != FS_NONE_HZ);
          lock_lim = LOCK_W'(LOCK_MCLK_CYCLES - 1);
          ref_edge = 1'b1;
        end
        REF_KIND_NONE: begin
          rate_ok = 1'b0;
        end
      endcase
      next_s.supported = rate_ok;

      unique case (i_mclk_ratio_select)
        RATIO_SEL_1024: next_s.mclk_mult = MULT_1024;
        RATIO_SEL_512:  next_s.mclk_mult = MULT_512;
        default:        next_s.mclk_mult = MULT_256;
      endcase

      // power-up or any change of reference or rate starts lock afresh
      restart = !i_pll_power || (i_pll_power && !s.pll_power_d)
                || (i_pll_ref_select != s.ref_d)
                || (i_sample_rate_select != s.fs_d);
      if (restart || !rate_ok) begin
        next_s.lock_cnt = '0;
        next_s.locked   = 1'b0;
        next_s.ref_seen = 1'b0;
      end else begin
        // no lock until a frame or bit clock reference has been seen to toggle; a master clock reference counts as seen
        next_s.ref_seen = s.ref_seen | ref_edge;
        if (!s.locked && (s.ref_seen || ref_edge)) begin
          if (s.lock_cnt >= lock_lim) begin
            next_s.locked = 1'b1;
          end else begin
            next_s.lock_cnt = s.lock_cnt + LOCK_W'(1);
          end
        end
      end
      next_s.data_invalid = i_pll_power && !i_master_select && !next_s.locked;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_clock_mode       = s.mode;
  assign o_pll_running      = s.pll_power_d;
  assign o_pll_locked       = s.locked;
  assign o_config_supported = s.supported;
  assign o_sample_rate_hz   = s.fs_hz;
  assign o_fs_range         = s.fs_range;
  assign o_mclk_ratio       = s.mclk_mult;
  assign o_data_invalid     = s.data_invalid;

  ////////////////////////////////////////////////////////////////////////////
  // link clock domain: clock generation on the master clock input

  typedef struct packed {
    logic [PHASE_W-1:0] phase;
    logic               locked_d;
    logic               mclk;
    logic               bclk;
    logic               fclk;
    logic               oe;
  } link_state_t;

  link_state_t            l;
  link_state_t            next_l;
  logic                   link_rst_n;
  logic [LINK_SYNC_W-1:0] link_cfg;
  logic                   l_en;
  logic                   l_master;
  logic                   l_pll;
  logic                   l_locked;
  logic                   l_mclk_en;
  logic [1:0]             l_div;
  logic                   l_bit_rate;

  // async assert, release synchronised to the link clock
  codec_clock_sync #(
    .WIDTH (1)
  ) u_link_rst (
    .i_clk (i_master_clock_in),
    .i_rst (i_sys_rst),
    .i_en  (1'b1),
    .i_d   (1'b1),
    .o_q   (link_rst_n)
  );

  // all sources are sys flops; fields are quasi-static control levels
  codec_clock_sync #(
    .WIDTH (LINK_SYNC_W)
  ) u_link_cfg (
    .i_clk (i_master_clock_in),
    .i_rst (i_sys_rst),
    .i_en  (1'b1),
    .i_d   ({s.clk_en_d, s.master, s.pll_power_d, s.locked, s.mclk_en, s.bit_rate,
             s.divider[0]}),
    .o_q   (link_cfg)
  );

  // divider msb travels in its own synchroniser to keep widths plain
  logic [0:0] div_hi;
  codec_clock_sync #(
    .WIDTH (1)
  ) u_link_div (
    .i_clk (i_master_clock_in),
    .i_rst (i_sys_rst),
    .i_en  (1'b1),
    .i_d   (s.divider[1]),
    .o_q   (div_hi)
  );

  assign l_en       = link_cfg[6];
  assign l_master   = link_cfg[5];
  assign l_pll      = link_cfg[4];
  assign l_locked   = link_cfg[3];
  assign l_mclk_en  = link_cfg[2];
  assign l_bit_rate = link_cfg[1];
  assign l_div      = {div_hi[0], link_cfg[0]};

  always_comb begin
    next_l = l;
    if (l_en) begin
      next_l.locked_d = l_locked;
      // realign the dividers on lock; the old phase may cut the first period short
      if (l_locked && !l.locked_d) begin
        next_l.phase = PHASE_ZERO;
      end else begin
        next_l.phase = l.phase + PHASE_STEP;
      end
      next_l.oe = l_master;
      if (l_master && l_pll && l_locked) begin
        next_l.bclk = l.phase[l_bit_rate ? BIT_64FS_IDX : BIT_32FS_IDX];
        next_l.fclk = l.phase[FRAME_IDX];
      end else begin
        // slave, unlocked, powered down or external modes: hold low, no runt pulses
        next_l.bclk = 1'b0;
        next_l.fclk = 1'b0;
      end
      if (l_pll && l_mclk_en) begin
        next_l.mclk = l_locked ? l.phase[l_div]
                               : (l.phase[0] & l.phase[2]);
      end else begin
        next_l.mclk = 1'b0;
      end
    end
  end

  always_ff @(posedge i_master_clock_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  assign o_master_clock_out = l.mclk;
  assign o_bit_clock        = l.bclk;
  assign o_frame_clock      = l.fclk;
  assign o_bit_clock_oe     = l.oe;
  assign o_frame_clock_oe   = l.oe;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_mode_decode;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_clk_en && i_pll_power && i_master_select |=> o_clock_mode == MODE_PLL_MASTER;
  endproperty
  a_mode_decode: assert property (p_mode_decode)
    else $error("pll master mode not decoded");

  property p_unsupported;
    @(posedge i_clk) disable iff (i_sys_rst)
    !o_config_supported |-> !o_pll_locked;
  endproperty
  a_unsupported: assert property (p_unsupported)
    else $error("lock reported on unsupported configuration");

  property p_restart;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_clk_en && i_pll_power && !o_pll_running |=> !o_pll_locked ##1 !o_pll_locked;
  endproperty
  a_restart: assert property (p_restart)
    else $error("lock held across pll power-up");

  property p_lock_time;
    @(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_pll_locked) |-> $past(s.lock_cnt) == $past(lock_lim) && $past(s.ref_seen || ref_edge);
  endproperty
  a_lock_time: assert property (p_lock_time)
    else $error("lock before lock time elapsed");

  property p_data_invalid;
    @(posedge i_clk) disable iff (i_sys_rst)
    (o_clock_mode inside {MODE_PLL_SLAVE_MCLK, MODE_PLL_SLAVE_FB}) && !o_pll_locked
      |-> o_data_invalid;
  endproperty
  a_data_invalid: assert property (p_data_invalid)
    else $error("unlocked pll slave data not marked invalid");

  property p_fs_48k;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_clk_en && i_sample_rate_select == FS_CODE_48K |=> o_sample_rate_hz == FS_48K_HZ;
  endproperty
  a_fs_48k: assert property (p_fs_48k)
    else $error("48 kHz code decoded wrongly");

  property p_ratio;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_clk_en && i_mclk_ratio_select == RATIO_SEL_1024 |=> o_mclk_ratio == MULT_1024;
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("1024fs ratio decoded wrongly");

  property p_float;
    @(posedge i_master_clock_in) disable iff (!link_rst_n)
    l_en && !l_master |=> !o_bit_clock_oe && !o_frame_clock_oe;
  endproperty
  a_float: assert property (p_float)
    else $error("clock pins driven in slave mode");

  property p_low_unlocked;
    @(posedge i_master_clock_in) disable iff (!link_rst_n)
    l_en && (!l_pll || !l_locked) |=> !o_bit_clock && !o_frame_clock;
  endproperty
  a_low_unlocked: assert property (p_low_unlocked)
    else $error("bit or frame clock active while unlocked");

  property p_mclk_off;
    @(posedge i_master_clock_in) disable iff (!link_rst_n)
    l_en && !l_mclk_en |=> !o_master_clock_out;
  endproperty
  a_mclk_off: assert property (p_mclk_off)
    else $error("master clock out active while disabled");

  property p_bit_64fs;
    @(posedge i_master_clock_in) disable iff (!link_rst_n)
    // only a true 64fs rise with no realign or rate switch just behind it
    ($rose(o_bit_clock) && $past(l_en) && $past(l_bit_rate) && $past(l.locked_d)
      && $past(l.phase[1:0]) == PHASE_ZERO[1:0])
      ##0 (l_en && l_locked && l_master && l_pll && l_bit_rate)[*4]
      |-> o_bit_clock ##1 !o_bit_clock;
  endproperty
  a_bit_64fs: assert property (p_bit_64fs)
    else $error("64fs bit clock high time wrong");

  c_locked: cover property (@(posedge i_clk) disable iff (i_sys_rst) $rose(o_pll_locked));
  c_frame_run: cover property (@(posedge i_master_clock_in) disable iff (!link_rst_n)
    o_frame_clock_oe && $rose(o_frame_clock));
  c_valid_data: cover property (@(posedge i_clk) disable iff (i_sys_rst) $fell(o_data_invalid));

endmodule

// ===== codec_clock_host_model.sv
`timescale 1ns/10ps
module codec_clock_host_model (
  input  wire logic i_link_clk,
  input  wire logic i_bit_oe,
  input  wire logic i_frame_oe,
  output logic      o_bit_pin,
  output logic      o_frame_pin
);
  logic [8:0] phase = 9'h000;
  // clocks are cut from the shared master clock, so they stay synchronous
  always @(posedge i_link_clk) phase <= phase + 9'h001;
  // never stopped while converters may run; host outputs are forced low when the device drives
  assign o_bit_pin   = !i_bit_oe && phase[3];
  assign o_frame_pin = !i_frame_oe && phase[8];
endmodule

// ===== codec_clock_mode_control_tb_top.sv
`timescale 1ns/10ps
module codec_clock_mode_control_tb_top
  import codec_clock_pkg::*;
;
  typedef struct packed {
    logic [2:0]  fl;
    logic [3:0]  rs;
    logic [3:0]  fs;
    clock_mode_t md;
    logic [15:0] hz;
  } row_t;
  logic clk = 1'b0, lclk = 1'b0, rst = 1'b1, ms = 1'b0, pp = 1'b0, brate = 1'b0, men = 1'b0;
  logic en = 1'b1;
  logic [3:0] rsel = 4'h0, fsel = 4'h0;
  logic [1:0] rat = 2'h0, div = 2'h0;
  logic mco, bc, bco, fc, fco, running, locked, sup, dinv, hb, hf;
  clock_mode_t mode;
  logic [15:0] hz;
  logic [1:0] rng, rto;
  wire bpin = bco ? bc : hb;
  wire fpin = fco ? fc : hf;
  int bad_count = 0, num_checks = 0, n, t;
  row_t rows [8];
  logic [1:0] rx [4] = '{2'h0, 2'h2, 2'h1, 2'h0};

  initial forever #20 clk = ~clk;
  initial begin
    #7;
    forever #62.5 lclk = ~lclk;
  end

  codec_clock_mode_control #(.LOCK_FRAME_CYCLES(64), .LOCK_BIT_CYCLES(16),
    .LOCK_MCLK_CYCLES(32)) codec_clock_mode_control_i (
    .i_clk(clk), .i_clk_en(en), .i_sys_rst(rst), .i_master_clock_in(lclk),
    .i_master_select(ms), .i_pll_power(pp), .i_pll_ref_select(rsel),
    .i_sample_rate_select(fsel), .i_mclk_ratio_select(rat), .i_mclk_out_divider(div),
    .i_mclk_out_enable(men), .i_bit_clock_rate(brate), .i_bit_clock(bpin),
    .i_frame_clock(fpin), .o_master_clock_out(mco), .o_bit_clock(bc), .o_bit_clock_oe(bco),
    .o_frame_clock(fc), .o_frame_clock_oe(fco), .o_clock_mode(mode),
    .o_pll_running(running), .o_pll_locked(locked), .o_config_supported(sup),
    .o_sample_rate_hz(hz), .o_fs_range(rng), .o_mclk_ratio(rto), .o_data_invalid(dinv));

  codec_clock_host_model codec_clock_host_model_i (.i_link_clk(lclk), .i_bit_oe(bco),
    .i_frame_oe(fco), .o_bit_pin(hb), .o_frame_pin(hf));

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // rises over one frame of 512 link cycles: 0 frame, 1 bit, 2 master out
  task cnt(input int sel);
    logic p, v;
    n = 0;
    @(negedge lclk);
    p = sel == 0 ? fc : sel == 1 ? bc : mco;
    repeat (512) begin
      @(negedge lclk);
      v = sel == 0 ? fc : sel == 1 ? bc : mco;
      if (v && !p) n++;
      p = v;
    end
    // hand back on the system clock's falling edge, where inputs may change
    @(negedge clk);
  endtask

  task wait_lock(input int lim);
    t = 0;
    while (locked !== 1'b1 && t < lim) begin
      @(negedge clk);
      t++;
      if (ms) chk({bc, fc}, 16'h0000);
    end
    chk(16'(t <= lim - 1), 16'h0001);
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    complete_run;
  end

  initial begin
    rows = '{'{3'b001, 4'h0, 4'h0, MODE_EXT_SLAVE, FS_8K_HZ},
             '{3'b101, 4'h0, 4'hb, MODE_EXT_MASTER, FS_48K_HZ},
             '{3'b011, 4'h4, 4'hf, MODE_PLL_SLAVE_MCLK, FS_44K1_HZ},
             '{3'b011, 4'h2, 4'h4, MODE_PLL_SLAVE_FB, FS_7K35_HZ},
             '{3'b111, 4'h7, 4'ha, MODE_PLL_MASTER, FS_32K_HZ},
             '{3'b110, 4'h5, 4'h1, MODE_PLL_MASTER, FS_12K_HZ},
             '{3'b110, 4'hd, 4'h8, MODE_PLL_MASTER, FS_NONE_HZ},
             '{3'b010, 4'h3, 4'hc, MODE_PLL_SLAVE_FB, FS_NONE_HZ}};
    repeat (12) @(negedge clk);
    chk({bco, fco, 1'b0, mode}, 16'h0000);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(mode), 16'(MODE_EXT_SLAVE));
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      {ms, pp} = rows[i].fl[2:1];
      rsel = rows[i].rs;
      fsel = rows[i].fs;
      rat = 2'(i);
      repeat (2) @(negedge clk);
      chk(16'(mode), 16'(rows[i].md));
      if (pp) chk(16'(sup), 16'(rows[i].fl[0]));
      chk(hz, rows[i].hz);
      chk(16'(rng), 16'(fsel[3:2]));
      chk(16'(rto), 16'(rx[i % 4]));
      chk(16'(running), 16'(pp));
      $display("row %0d done", i);
    end
    // master with master clock reference, first frame after lock skipped
    pp = 1'b0;
    repeat (4) @(negedge clk);
    {ms, pp, rsel, fsel, men, div} = {2'b11, 4'h4, 4'h0, 1'b1, 2'h3};
    wait_lock(40);
    chk({bco, fco}, 16'h0003);
    cnt(0);
    cnt(0);
    chk(16'(n), 16'h0001);
    cnt(1);
    chk(16'(n), 16'h0020);
    cnt(2);
    chk(16'(n), 16'h0020);
    {brate, div} = 3'b100;
    cnt(2);
    cnt(2);
    chk(16'(n), 16'h0100);
    cnt(1);
    chk(16'(n), 16'h0040);
    pp = 1'b0;
    repeat (10) @(negedge lclk);
    cnt(1);
    chk({n[7:0], bc, fc, 6'h00}, 16'h0000);
    $display("pll master test done");
    {ms, pp, men} = 3'b010;
    repeat (3) @(negedge clk);
    chk(16'(dinv), 16'h0001);
    wait_lock(40);
    chk(16'(dinv), 16'h0000);
    cnt(2);
    chk({n[7:0], bco, 7'h00}, 16'h0000);
    men = 1'b1;
    cnt(2);
    cnt(2);
    chk(16'(n), 16'h0100);
    rsel = 4'h0;
    repeat (2) @(negedge clk);
    wait_lock(1800);
    $display("pll slave test done");
    // clock enable low freezes the rate decode until it returns
    en = 1'b0;
    fsel = 4'hb;
    repeat (3) @(negedge clk);
    chk(hz, FS_8K_HZ);
    en = 1'b1;
    repeat (2) @(negedge clk);
    chk(hz, FS_48K_HZ);
    $display("clock enable test done");
    complete_run;
  end
endmodule
